// ### src/asc_pkg.sv
// Shared constants and types of the serial control block of the converter
package asc_pkg;

    // Control byte field positions, first bit in at the top
    localparam int BIT_START    = 7;
    localparam int BIT_SPAN     = 6;
    localparam int BIT_POLARITY = 5;
    localparam int BIT_POWER    = 4;
    localparam int BIT_DEPTH    = 3;
    localparam int BIT_TIMING   = 2;
    localparam int BIT_RESERVED = 1;
    localparam int BIT_REF      = 0;

    // Widths
    localparam int CTRL_BITS   = 8;
    localparam int RESULT_BITS = 12;

    // Serial clock edge counts within one control byte
    localparam logic [3:0] EDGE_START   = 4'h1;
    localparam logic [3:0] EDGE_ACQUIRE = 4'h4;
    localparam logic [3:0] EDGE_HOLD    = 4'h8;

    // Result bits already sent: eight means result_bit_four is out
    localparam logic [3:0] SENT_ONE      = 4'h1;
    localparam logic [3:0] SENT_BIT_FOUR = 4'h8;
    localparam logic [3:0] SENT_ALL      = 4'hC;

    // Reset values
    localparam logic                   RESET_SPAN     = 1'b0;
    localparam logic                   RESET_POLARITY = 1'b0;
    localparam logic                   RESET_REF      = 1'b0;
    localparam logic [RESULT_BITS-1:0] RESET_RESULT   = 12'h000;
    localparam logic [CTRL_BITS-1:0]   RESET_CTRL     = 8'h00;

    // Receive side sequencing
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_BYTE = 3'b010,
        RX_CONV = 3'b100
    } asc_rx_e;

    // Power state of the converter core
    typedef enum logic [3:0] {
        PWR_ACTIVE  = 4'b0001,
        PWR_PENDING = 4'b0010,
        PWR_STANDBY = 4'b0100,
        PWR_FULL    = 4'b1000
    } asc_pwr_e;

endpackage

// ### src/asc_sync.sv
// Two flip-flop level synchroniser of configurable width and reset value
`timescale 1ns/100ps
`default_nettype none

module asc_sync #(
    parameter int                WIDTH      = 1,
    parameter logic [WIDTH-1:0]  RESET_VALUE = '0
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage;

    // First stage feeds only the second one
    always_ff @(posedge clock) begin
        if (reset) begin
            stage <= RESET_VALUE;
            q     <= RESET_VALUE;
        end else begin
            stage <= d;
            q     <= stage;
        end
    end

endmodule

`default_nettype wire

// ### src/asc_sample_hold.sv
// Sample holder: follows the input code while the link asks for tracking
`timescale 1ns/100ps
`default_nettype none

module asc_sample_hold (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        trackLink,
    input  wire logic [11:0] sampleCode,
    output logic      [11:0] heldCode
);

    logic trackSync;

    asc_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) trackSyncInst (
        .clock (clock),
        .reset (reset),
        .d     (trackLink),
        .q     (trackSync)
    );

    // Frozen within three clocks of hold; link reads it one serial period later
    always_ff @(posedge clock) begin
        if (reset) begin
            heldCode <= asc_pkg::RESET_RESULT;
        end else if (trackSync) begin
            heldCode <= sampleCode;
        end
    end

endmodule

`default_nettype wire

// ### src/asc_serial_control.sv
// Serial control byte receiver, conversion sequencer and result shifter
// Summary of operation
// - Input bit sampled on rising serial clock while chip select low.
// - When idle, first one after chip select low starts a control byte.
// - During conversion, start bit recognised only after result_bit_four left.
// - Start bit in a new frame before result_bit_four aborts and restarts.
// - Chip select alone never converts; acquisition starts at fourth bit.
// - Hold and conversion start at eighth falling edge after start bit.
// - Twelve result bits MSB first on falling edges, then zeros.
// - Unipolar gives straight binary, bipolar gives two's complement.
// - Output released to high impedance when chip select is high.
// - Power-up: active, external reference, result cleared, await start.
// - Span bit picks doubled span, polarity bit picks bipolar.
// - Power control one: normal, mode bits ignored, standby between conversions.
// - Power control zero: depth bit picks full, timing bit picks immediate.
// - Delayed waits conversion end; immediate powers down at hold, no conversion.
// - Serial interface keeps working in every power-down mode.
// - Start bit wakes from power-down without converting; full disables reference.
// - Reference bit zero selects external, one selects internal reference.
// - Byte host reads zeros, then zero and MSB..bit five, then rest.
// - Byte: start, span, polarity, power, depth, timing, reserved, reference.
`timescale 1ns/100ps
`default_nettype none

module asc_serial_control (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        sclk,
    input  wire logic        chipSelect_n,
    input  wire logic        din,
    input  wire logic [11:0] sampleCode,
    output logic             sdo,
    output logic             sdoEnable_n,
    output logic             spanSelect,
    output logic             polaritySelect,
    output logic             referenceInternal,
    output logic             standbyPowerdown,
    output logic             fullPowerdown
);

    ////////////////////////////////////////////////////////////////////////////
    // State types

    typedef struct packed {
        asc_pkg::asc_rx_e state;
        logic [3:0]       count;
        logic [7:0]       shift;
        logic [7:0]       ctrlByte;
        logic             fresh;
        logic             newFrame;
        logic             wake;
    } asc_rise_s;

    typedef struct packed {
        logic [11:0]       shift;
        logic              sdo;
        logic [3:0]        sent;
        logic              busy;
        logic              loadPending;
        logic              track;
        asc_pkg::asc_pwr_e pwr;
        logic              pendDepth;
        logic              span;
        logic              polarity;
        logic              refSel;
        logic              standby;
    } asc_fall_s;

    asc_rise_s   rise;
    asc_rise_s   next_rise;
    asc_fall_s   fall;
    asc_fall_s   next_fall;
    logic        linkReset;
    logic [11:0] heldCode;
    logic [5:0]  statusSync;

    ////////////////////////////////////////////////////////////////////////////
    // Link reset, brought into the serial clock domain

    // Needs a few serial clock edges during reset to take effect
    asc_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) linkResetSync (
        .clock (sclk),
        .reset (1'b0),
        .d     (reset),
        .q     (linkReset)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Rising edge side: control byte reception

    always_comb begin
        next_rise       = rise;
        next_rise.fresh = 1'b0;
        if (chipSelect_n) begin
            next_rise.newFrame = 1'b1;
        end else begin
            case (rise.state)
                asc_pkg::RX_IDLE: begin
                    if (din) begin
                        next_rise.state    = asc_pkg::RX_BYTE;
                        next_rise.count    = asc_pkg::EDGE_START;
                        next_rise.shift    = 8'h01;
                        next_rise.newFrame = 1'b0;
                        next_rise.wake     = (fall.pwr == asc_pkg::PWR_STANDBY)
                                          || (fall.pwr == asc_pkg::PWR_FULL);
                    end
                end
                asc_pkg::RX_BYTE: begin
                    next_rise.shift = {rise.shift[6:0], din};
                    next_rise.count = rise.count + 4'h1;
                    if (rise.count == asc_pkg::EDGE_HOLD - 4'h1) begin
                        next_rise.ctrlByte = {rise.shift[6:0], din};
                        next_rise.state    = asc_pkg::RX_CONV;
                        next_rise.fresh    = 1'b1;
                    end
                end
                asc_pkg::RX_CONV: begin
                    // Before result_bit_four only a fresh frame may restart
                    if (din && (!fall.busy || rise.newFrame)) begin
                        next_rise.state    = asc_pkg::RX_BYTE;
                        next_rise.count    = asc_pkg::EDGE_START;
                        next_rise.shift    = 8'h01;
                        next_rise.newFrame = 1'b0;
                        next_rise.wake     = (fall.pwr == asc_pkg::PWR_STANDBY)
                                          || (fall.pwr == asc_pkg::PWR_FULL);
                    end else if (!fall.busy) begin
                        next_rise.state = asc_pkg::RX_IDLE;
                    end
                end
                default: begin
                    next_rise.state = asc_pkg::RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sclk) begin
        if (linkReset) begin
            rise <= '{state: asc_pkg::RX_IDLE, count: 4'h0, shift: 8'h00,
                      ctrlByte: asc_pkg::RESET_CTRL, fresh: 1'b0, newFrame: 1'b0,
                      wake: 1'b0};
        end else begin
            rise <= next_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Falling edge side: acquisition, hold, power and result shifting

    always_comb begin
        next_fall = fall;
        // Result shifting continues in every power state
        if (fall.loadPending) begin
            next_fall.sdo         = heldCode[11] ^ fall.polarity;
            next_fall.shift       = {heldCode[10:0], 1'b0};
            next_fall.sent        = asc_pkg::SENT_ONE;
            next_fall.loadPending = 1'b0;
        end else begin
            next_fall.sdo   = fall.shift[11];
            next_fall.shift = {fall.shift[10:0], 1'b0};
            if (fall.sent != asc_pkg::SENT_ALL) begin
                next_fall.sent = fall.sent + 4'h1;
            end
        end
        if (next_fall.sent == asc_pkg::SENT_BIT_FOUR) begin
            next_fall.busy = 1'b0;
        end
        // Delayed power-down takes effect only once the conversion ends
        if (fall.pwr == asc_pkg::PWR_PENDING && next_fall.sent == asc_pkg::SENT_ALL
                && !next_fall.loadPending) begin
            next_fall.pwr = fall.pendDepth ? asc_pkg::PWR_FULL : asc_pkg::PWR_STANDBY;
        end
        // Acquisition opens at the fourth falling edge of a real byte
        if (rise.state == asc_pkg::RX_BYTE && rise.count == asc_pkg::EDGE_ACQUIRE
                && !rise.wake) begin
            next_fall.track = 1'b1;
        end
        // New start bit while the old result is not past result_bit_four
        if (rise.state == asc_pkg::RX_BYTE && rise.count == asc_pkg::EDGE_START
                && fall.busy) begin
            next_fall.busy        = 1'b0;
            next_fall.loadPending = 1'b0;
            next_fall.shift       = asc_pkg::RESET_RESULT;
            next_fall.sdo         = 1'b0;
            next_fall.sent        = asc_pkg::SENT_ALL;
            next_fall.track       = 1'b0;
        end
        // Eighth falling edge: hold, decode control byte
        if (rise.fresh) begin
            next_fall.track = 1'b0;
            if (rise.wake) begin
                next_fall.pwr  = asc_pkg::PWR_ACTIVE;
                next_fall.busy = 1'b0;
            end else begin
                next_fall.span     = rise.ctrlByte[asc_pkg::BIT_SPAN];
                next_fall.polarity = rise.ctrlByte[asc_pkg::BIT_POLARITY];
                next_fall.refSel   = rise.ctrlByte[asc_pkg::BIT_REF];
                if (rise.ctrlByte[asc_pkg::BIT_POWER]) begin
                    next_fall.pwr         = asc_pkg::PWR_ACTIVE;
                    next_fall.busy        = 1'b1;
                    next_fall.loadPending = 1'b1;
                end else if (rise.ctrlByte[asc_pkg::BIT_TIMING]) begin
                    next_fall.pwr  = rise.ctrlByte[asc_pkg::BIT_DEPTH] ?
                                     asc_pkg::PWR_FULL : asc_pkg::PWR_STANDBY;
                    next_fall.busy = 1'b0;
                end else begin
                    next_fall.pwr         = asc_pkg::PWR_PENDING;
                    next_fall.pendDepth   = rise.ctrlByte[asc_pkg::BIT_DEPTH];
                    next_fall.busy        = 1'b1;
                    next_fall.loadPending = 1'b1;
                end
            end
        end
        // Normal mode idles in standby between conversions
        next_fall.standby = (next_fall.pwr == asc_pkg::PWR_STANDBY)
                         || (next_fall.pwr == asc_pkg::PWR_ACTIVE
                             && next_fall.sent == asc_pkg::SENT_ALL
                             && !next_fall.loadPending && !next_fall.track);
    end

    always_ff @(negedge sclk) begin
        if (linkReset) begin
            fall <= '{shift: asc_pkg::RESET_RESULT, sdo: 1'b0,
                      sent: asc_pkg::SENT_ALL, busy: 1'b0, loadPending: 1'b0,
                      track: 1'b0, pwr: asc_pkg::PWR_ACTIVE, pendDepth: 1'b0,
                      span: asc_pkg::RESET_SPAN, polarity: asc_pkg::RESET_POLARITY,
                      refSel: asc_pkg::RESET_REF, standby: 1'b0};
        end else begin
            fall <= next_fall;
        end
    end

    assign sdo = fall.sdo;

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into the system clock domain

    asc_sample_hold sampleHold (
        .clock      (clock),
        .reset      (reset),
        .trackLink  (fall.track),
        .sampleCode (sampleCode),
        .heldCode   (heldCode)
    );

    // Status levels change only at chip select, hold or power events, so bitwise sync suffices
    asc_sync #(.WIDTH(6), .RESET_VALUE(6'h20)) statusSyncInst (
        .clock (clock),
        .reset (reset),
        .d     ({chipSelect_n, fall.span, fall.polarity,
                 fall.refSel && fall.pwr != asc_pkg::PWR_FULL,
                 fall.standby, fall.pwr == asc_pkg::PWR_FULL}),
        .q     (statusSync)
    );

    // Release lags chip select by up to two system clocks
    assign sdoEnable_n       = statusSync[5];
    assign spanSelect        = statusSync[4];
    assign polaritySelect    = statusSync[3];
    assign referenceInternal = statusSync[2];
    assign standbyPowerdown  = statusSync[1];
    assign fullPowerdown     = statusSync[0];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_sample_gate: assert property (@(posedge sclk) disable iff (linkReset)
        chipSelect_n |=> $stable(rise.shift) && $stable(rise.state))
        else $error("control shift moved while chip select high");

    chk_start_idle: assert property (@(posedge sclk) disable iff (linkReset)
        (rise.state == asc_pkg::RX_IDLE && !chipSelect_n && din)
        |=> (rise.state == asc_pkg::RX_BYTE && rise.count == asc_pkg::EDGE_START))
        else $error("start bit from idle not taken");

    chk_early_start: assert property (@(posedge sclk) disable iff (linkReset)
        (rise.state == asc_pkg::RX_CONV && fall.busy && !rise.newFrame)
        |=> rise.state == asc_pkg::RX_CONV)
        else $error("start bit taken before result bit four");

    chk_abort_restart: assert property (@(posedge sclk) disable iff (linkReset)
        (rise.state == asc_pkg::RX_CONV && fall.busy && rise.newFrame
         && !chipSelect_n && din)
        |=> rise.state == asc_pkg::RX_BYTE ##1 !fall.busy)
        else $error("new frame start did not abort conversion");

    chk_track_start: assert property (@(negedge sclk) disable iff (linkReset)
        $rose(fall.track) |-> ($past(rise.count) == asc_pkg::EDGE_ACQUIRE && !$past(rise.wake)))
        else $error("acquisition opened on wrong edge");

    chk_hold_edge: assert property (@(negedge sclk) disable iff (linkReset)
        (rise.fresh && !rise.wake && rise.ctrlByte[asc_pkg::BIT_POWER])
        |=> (!fall.track && fall.loadPending) ##1 (fall.sent == asc_pkg::SENT_ONE) ##7 !fall.busy)
        else $error("hold or result timing wrong");

    chk_trailing_zero: assert property (@(negedge sclk) disable iff (linkReset)
        (fall.sent == asc_pkg::SENT_ALL && !fall.loadPending) |=> !fall.sdo)
        else $error("non-zero bit after twelve result bits");

    chk_code_format: assert property (@(negedge sclk) disable iff (linkReset)
        fall.loadPending |=> fall.sdo == ($past(heldCode[11]) ^ $past(fall.polarity)))
        else $error("result MSB coding wrong");

    chk_immediate_pd: assert property (@(negedge sclk) disable iff (linkReset)
        (rise.fresh && !rise.wake && !rise.ctrlByte[asc_pkg::BIT_POWER]
         && rise.ctrlByte[asc_pkg::BIT_TIMING])
        |=> (!fall.loadPending && !fall.busy && fall.pwr != asc_pkg::PWR_ACTIVE))
        else $error("immediate power-down still converted");

    chk_wake_only: assert property (@(negedge sclk) disable iff (linkReset)
        (rise.fresh && rise.wake)
        |=> (fall.pwr == asc_pkg::PWR_ACTIVE && !fall.loadPending))
        else $error("wake byte converted or did not wake");

    chk_dout_release: assert property (@(posedge clock) disable iff (reset)
        $rose(chipSelect_n) |-> ##[1:3] sdoEnable_n)
        else $error("output not released after chip select high");

endmodule

`default_nettype wire

// ### tb/asc_host_model.sv
// Serial host model: drives the link clock, chip select and control bits
`timescale 1ns/100ps
`default_nettype none

module asc_host_model (
    output logic      sclk,
    output logic      chipSelect_n,
    output logic      din,
    input  wire logic sdoWire
);

    ////////////////////////////////////////////////////////////////////////
    // Idle state: clock low, device deselected; outside frames the clock runs only in pulse
    initial begin
        sclk = 1'h0;
        chipSelect_n = 1'h1;
        din = 1'h0;
    end

    // Deselected clocks, used during reset and to mark a new frame
    task automatic pulse(input int n);
        repeat (n) begin
            #16 sclk = 1'h1;
            #16 sclk = 1'h0;
        end
    endtask

    // One frame, MSB first; data changes after falling, sampled at rising
    task automatic xfer(input int n, input logic [39:0] bits, output logic [39:0] cap);
        cap = '0;
        chipSelect_n = 1'h0;
        // Gap lets the registered output enable catch up with chip select
        #32;
        for (int k = 0; k < n; k++) begin
            din = bits[39-k];
            #16 sclk = 1'h1;
            cap[39-k] = sdoWire;
            #16 sclk = 1'h0;
        end
        din = 1'h0;
        #16 chipSelect_n = 1'h1;
    endtask

endmodule
`default_nettype wire

// ### tb/tb_asc_serial_control.sv
// Self-checking bench of the serial control block
`timescale 1ns/100ps
`default_nettype none

module tb_asc_serial_control;

    logic        clock;
    logic        reset;
    logic        sclk;
    logic        chipSelect_n;
    logic        din;
    logic [11:0] sampleCode;
    logic        sdo;
    logic        sdoEnable_n;
    logic        spanSelect;
    logic        polaritySelect;
    logic        referenceInternal;
    logic        standbyPowerdown;
    logic        fullPowerdown;
    wire  logic  sdoWire;
    logic [39:0] cap;
    logic [1:0]  mode;
    int          num_errors;
    int          cmp_count;

    ////////////////////////////////////////////////////////////////////////
    // Released line shows the inverse, so a stale value never passes
    assign sdoWire = sdoEnable_n ? ~sdo : sdo;

    // System clock, 8 ns period
    initial clock = 1'h0;
    always #4 clock = ~clock;

    asc_serial_control asc_serial_control_i (
        .clock            (clock),
        .reset            (reset),
        .sclk             (sclk),
        .chipSelect_n     (chipSelect_n),
        .din              (din),
        .sampleCode       (sampleCode),
        .sdo              (sdo),
        .sdoEnable_n      (sdoEnable_n),
        .spanSelect       (spanSelect),
        .polaritySelect   (polaritySelect),
        .referenceInternal(referenceInternal),
        .standbyPowerdown (standbyPowerdown),
        .fullPowerdown    (fullPowerdown)
    );

    asc_host_model asc_host_model_i (
        .sclk        (sclk),
        .chipSelect_n(chipSelect_n),
        .din         (din),
        .sdoWire     (sdoWire)
    );

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and helpers
    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Status outputs lag the link by a few system clocks
    task automatic settle();
        repeat (4) @(negedge clock);
    endtask

    // Single conversion as seen by a byte host: 9 zeros, code, 3 zeros
    function automatic logic [39:0] res(input logic [11:0] c);
        return {9'h0, c, 19'h0};
    endfunction

    task automatic run(input int n, input logic [39:0] bits, input logic [11:0] code);
        @(negedge clock);
        sampleCode = code;
        asc_host_model_i.xfer(n, bits, cap);
        settle();
        check("sdo_released", sdoEnable_n, 40'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard: a run past the limit counts as a mismatch
    initial begin
        repeat (100000) @(posedge clock);
        num_errors++;
        $display("[ERR] run_limit expected finish seen hang");
        print_verdict();
    end

    // Main sequence; link reset needs the serial clock running
    initial begin
        num_errors = 0;
        cmp_count = 0;
        reset = 1'h1;
        sampleCode = 12'h000;
        asc_host_model_i.pulse(5);
        repeat (4) @(negedge clock);
        reset = 1'h0;
        asc_host_model_i.pulse(4);
        settle();
        check("span", spanSelect, 40'h0);
        check("ref", referenceInternal, 40'h0);
        check("full", fullPowerdown, 40'h0);
        check("standby", standbyPowerdown, 40'h1);
        // Normal mode ignores the mode bits; doubled span, internal ref
        run(24, {8'hDD, 32'h0}, 12'hA5C);
        check("result", cap, res(12'hA5C));
        check("span", spanSelect, 40'h1);
        check("ref", referenceInternal, 40'h1);
        check("full", fullPowerdown, 40'h0);
        check("standby", standbyPowerdown, 40'h1);
        // Bipolar gives two's complement
        run(24, {8'hB0, 32'h0}, 12'h3F0);
        check("bipolar", cap, res(12'hBF0));
        check("polarity", polaritySelect, 40'h1);
        check("ref", referenceInternal, 40'h0);
        // Ones before bit four goes out in the same frame are ignored
        run(24, {8'h91, 8'hFF, 24'h0}, 12'h123);
        check("ones_ignored", cap, res(12'h123));
        // Sixteen leading zeros, then the byte; chip select alone does nothing
        run(40, {16'h0, 8'h91, 16'h0}, 12'h456);
        check("lead_zeros", cap, {25'h0, 12'h456, 3'h0});
        // New frame before bit four aborts the running conversion
        @(negedge clock);
        // Old bit seven is zero: the first edge of the new frame still shows it
        sampleCode = 12'hF00;
        asc_host_model_i.xfer(12, {8'h91, 32'h0}, cap);
        check("pre_abort", cap, {9'h0, 3'h7, 28'h0});
        asc_host_model_i.pulse(1);
        run(24, {8'h91, 32'h0}, 12'h70E);
        check("abort", cap, res(12'h70E));
        // Back to back at 16 clocks per conversion, code changed mid-frame
        @(negedge clock);
        sampleCode = 12'hC31;
        fork
            asc_host_model_i.xfer(40, {8'h91, 8'h00, 8'h91, 16'h0}, cap);
            begin
                repeat (13) @(posedge sclk);
                @(negedge clock);
                sampleCode = 12'h5A7;
                check("sdo_driven", sdoEnable_n, 40'h0);
            end
        join
        settle();
        check("pair", cap, {9'h0, 12'hC31, 4'h0, 12'h5A7, 3'h0});
        // All four power-down modes, each followed by a wake byte
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            run(24, {4'h8, mode, 2'h1, 32'h0}, 12'h9C3);
            if (!mode[0]) begin
                check("delayed_result", cap, res(12'h9C3));
            end else begin
                check("no_conversion", cap, 40'h0);
            end
            check("full", fullPowerdown, {39'h0, mode[1]});
            check("standby", standbyPowerdown, {39'h0, ~mode[1]});
            check("ref", referenceInternal, {39'h0, ~mode[1]});
            run(8, {8'h80, 32'h0}, 12'h9C3);
            check("woken", fullPowerdown, 40'h0);
            check("ref_back", referenceInternal, 40'h1);
        end
        print_verdict();
    end

endmodule
`default_nettype wire
